// file: hdl/epdsc_core.sv
// Command decoder: status read, option/user id store, border control
`timescale 1ns/1ps
`include "epdsc_regs.svh"
module epdsc_core #(
    parameter logic [1:0] CHIP_ID = `EPDSC_CHIP_ID
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Serial link
    input wire logic link_sclk,
    input wire logic link_cs_n,
    input wire logic link_dc,
    input wire logic link_sda_in,
    output logic link_sda_out,
    output logic link_sda_oe_n,
    // Controller state
    input wire logic hv_not_ready,
    input wire logic chip_supply_low,
    input wire logic busy,
    input wire logic [5:0] waveform_setting,
    // Stored settings
    output logic [79:0] display_option,
    output logic [79:0] user_identifier,
    output logic spare_common_electrode_voltage_sel,
    output logic [35:0] display_mode2,
    output logic [31:0] module_id,
    output logic alternating_ram_buffer_active,
    output epdsc_pkg::epdsc_border_t border_waveform_select,
    output epdsc_pkg::epdsc_bdrive_t border_drive_output,
    output logic read_ram_red
);
    import epdsc_pkg::*;

    // ************************************************************
    // Pin synchronisation and byte shifting
    // ************************************************************
    logic [`EPDSC_SYNC_W-1:0] pins_s;
    logic sclk_s;
    logic cs_n_s;
    logic dc_s;
    logic sda_s;
    logic hv_s;
    logic vci_s;
    logic rx_valid;
    logic rx_dc;
    logic [7:0] rx_byte;
    logic sdo;
    logic tx_load;
    epdsc_status_t controller_status;

    epdsc_sync u_sync (
        .mclk(mclk),
        .reset(reset),
        .din({link_sclk, link_cs_n, link_dc, link_sda_in,
              hv_not_ready, chip_supply_low}),
        .dout(pins_s)
    );

    assign {sclk_s, cs_n_s, dc_s, sda_s, hv_s, vci_s} = pins_s;

    epdsc_spi_shift u_shift (
        .mclk(mclk),
        .reset(reset),
        .sclk_s(sclk_s),
        .cs_n_s(cs_n_s),
        .sdi_s(sda_s),
        .dc_s(dc_s),
        .tx_load(tx_load),
        .tx_byte(controller_status),
        .sdo(sdo),
        .rx_valid(rx_valid),
        .rx_byte(rx_byte),
        .rx_dc(rx_dc)
    );

    // ************************************************************
    // Command decode
    // ************************************************************
    logic cmd_v;
    logic par_v;
    epdsc_ctx_t ctx;
    epdsc_ctx_t next_ctx;
    logic [3:0] idx;

    assign cmd_v = rx_valid && !rx_dc; // [RULE18]
    assign par_v = rx_valid && rx_dc; // [RULE18]
    assign tx_load = cmd_v && (rx_byte == `EPDSC_CMD_STATUS); // [RULE1]

    always_comb begin
        unique case (rx_byte)
            `EPDSC_CMD_STATUS: next_ctx = CTX_STATUS;
            `EPDSC_CMD_OPTION: next_ctx = CTX_OPTION;
            `EPDSC_CMD_USERID: next_ctx = CTX_USERID;
            `EPDSC_CMD_BORDER: next_ctx = CTX_BORDER;
            `EPDSC_CMD_RDSEL: next_ctx = CTX_RDSEL;
            default: next_ctx = CTX_IDLE;
        endcase
    end

    // Unknown commands park in idle so their data bytes fall away
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ctx <= CTX_IDLE;
        end else if (cmd_v) begin
            ctx <= next_ctx;
        end
    end

    // Index saturates: bytes past the tenth are dropped
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            idx <= 4'h0;
        end else if (cmd_v) begin
            idx <= 4'h0; // [RULE19]
        end else if (par_v && (idx != `EPDSC_NBYTES)) begin
            idx <= idx + 4'h1; // [RULE19]
        end
    end

    // ************************************************************
    // Status byte
    // ************************************************************
    // Bits 5 and 4 follow the detectors as they stand; the host must
    // have run its detect commands before believing them [RULE5]
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            controller_status <= '{chip_id: CHIP_ID, default: '0};
        end else begin
            controller_status.zero_hi <= 2'h0;
            controller_status.hv_not_ready <= hv_s; // [RULE1]
            controller_status.supply_low <= vci_s; // [RULE2]
            controller_status.zero_3 <= 1'b0;
            controller_status.busy <= busy; // [RULE3]
            controller_status.chip_id <= CHIP_ID; // [RULE4]
        end
    end

    // The pin is only driven while a status read is in progress
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            link_sda_oe_n <= 1'b1;
            link_sda_out <= 1'b0;
        end else begin
            link_sda_oe_n <= !(ctx == CTX_STATUS && !cs_n_s && dc_s);
            link_sda_out <= sdo; // [RULE1]
        end
    end

    // ************************************************************
    // Option and user id storage
    // ************************************************************
    logic [7:0] opt [`EPDSC_NBYTES];
    logic [7:0] uid [`EPDSC_NBYTES];
    logic wr_opt;
    logic wr_uid;

    assign wr_opt = par_v && (ctx == CTX_OPTION);
    assign wr_uid = par_v && (ctx == CTX_USERID);

    genvar g;
    generate
        for (g = 0; g < `EPDSC_NBYTES; g++) begin : g_byte
            localparam logic [7:0] MASK = (g == 0) ? `EPDSC_OPT_A_MASK :
                (g == `EPDSC_OPT_F_IDX) ? `EPDSC_OPT_F_MASK : 8'hFF;
            always_ff @(posedge mclk or posedge reset) begin
                if (reset) begin
                    opt[g] <= 8'h00;
                end else if (wr_opt && (idx == 4'(g))) begin
                    opt[g] <= rx_byte & MASK; // [RULE6] [RULE7] [RULE19]
                end
            end
            always_ff @(posedge mclk or posedge reset) begin
                if (reset) begin
                    uid[g] <= 8'h00;
                end else if (wr_uid && (idx == 4'(g))) begin
                    uid[g] <= rx_byte; // [RULE12] [RULE19]
                end
            end
            // First byte sits in the low lane of each export
            assign display_option[g*8 +: 8] = opt[g]; // [RULE11]
            assign user_identifier[g*8 +: 8] = uid[g]; // [RULE12]
        end
    endgenerate

    assign spare_common_electrode_voltage_sel = opt[0][7]; // [RULE6]
    assign display_mode2 = {opt[5][3:0], opt[4], opt[3], opt[2],
                            opt[1]}; // [RULE7]
    assign module_id = {opt[9], opt[8], opt[7], opt[6]}; // [RULE10]

    // Out-of-range settings count as mode one, so never alternate
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            alternating_ram_buffer_active <= 1'b0;
        end else begin
            alternating_ram_buffer_active <=
                opt[`EPDSC_OPT_F_IDX][`EPDSC_PP_BIT] && // [RULE8]
                (waveform_setting < `EPDSC_NSET) &&
                display_mode2[waveform_setting]; // [RULE9]
        end
    end

    // ************************************************************
    // Border control and read plane select
    // ************************************************************
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            border_waveform_select <= `EPDSC_BORDER_POR; // [RULE13]
        end else if (par_v && ctx == CTX_BORDER && idx == 4'h0) begin
            border_waveform_select <= rx_byte & `EPDSC_BORDER_MASK;
        end
    end

    // Level and table fields only count in their own source mode
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            border_drive_output <= '{hiz: 1'b1, default: '0};
        end else begin
            border_drive_output.hiz <=
                border_waveform_select.source == BSRC_HIZ; // [RULE13]
            border_drive_output.common <=
                border_waveform_select.source == BSRC_COMMON;
            border_drive_output.fixed <=
                border_waveform_select.source == BSRC_FIXED;
            border_drive_output.grey <=
                border_waveform_select.source == BSRC_GREY;
            border_drive_output.level <=
                (border_waveform_select.source == BSRC_FIXED) ?
                border_waveform_select.level : 2'h0; // [RULE14]
            border_drive_output.red_common <=
                (border_waveform_select.source == BSRC_GREY) &&
                border_waveform_select.red_common; // [RULE15]
            border_drive_output.lut <=
                (border_waveform_select.source == BSRC_GREY) ?
                border_waveform_select.lut : 2'h0; // [RULE16]
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            read_ram_red <= 1'b0;
        end else if (par_v && ctx == CTX_RDSEL && idx == 4'h0) begin
            read_ram_red <= rx_byte[`EPDSC_RDSEL_BIT]; // [RULE17]
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);

    a_status_hv: assert property ( // [RULE1]
        tx_load |-> controller_status.hv_not_ready == $past(hv_s))
        else $error("status bit 5 does not follow ready detector");

    a_status_vci: assert property ( // [RULE2]
        $rose(vci_s) |=> controller_status.supply_low)
        else $error("status bit 4 missed supply-low detect");

    a_status_busy: assert property ( // [RULE3]
        busy [*2] |-> controller_status.busy)
        else $error("status bit 2 not showing busy");

    a_chip_id: assert property ( // [RULE4]
        controller_status.chip_id == CHIP_ID &&
        controller_status.zero_3 == 1'b0)
        else $error("chip code or zero bit wrong in status");

    a_spare_sel: assert property ( // [RULE6]
        wr_opt && idx == 4'h0 |=> spare_common_electrode_voltage_sel == $past(rx_byte[7]))
        else $error("spare selection not stored from first byte");

    a_mode_bits: assert property ( // [RULE7]
        wr_opt && idx == 4'h1 |=> display_mode2[7:0] == $past(rx_byte))
        else $error("mode bits 7:0 not stored from second byte");

    a_pp_mode1: assert property ( // [RULE9]
        !display_mode2[waveform_setting] [*2] |->
            !alternating_ram_buffer_active)
        else $error("alternation active for a mode one setting");

    a_uid_last: assert property ( // [RULE12]
        wr_uid && idx == 4'h9 |=> user_identifier[79:72] == $past(rx_byte))
        else $error("tenth user id byte not stored");

    a_border_fix: assert property ( // [RULE14]
        border_waveform_select.source == BSRC_FIXED |=>
            border_drive_output.level == $past(border_waveform_select.level))
        else $error("fixed border level not applied");

    a_cmd_restart: assert property ( // [RULE19]
        cmd_v |=> idx == 4'h0 && !tx_load)
        else $error("new command did not restart byte index");

    a_sda_release: assert property ( // [RULE18]
        cs_n_s [*2] |-> link_sda_oe_n)
        else $error("data pin driven while deselected");

    c_status_read: cover property (tx_load ##[1:600] !link_sda_oe_n);
    c_option_full: cover property (wr_opt && idx == 4'h9);
    c_border_grey: cover property (border_drive_output.grey);
    c_pp_active: cover property (alternating_ram_buffer_active);

endmodule : epdsc_core

// file: hdl/epdsc_regs.svh
// Command codes, field masks and reset values of the status/option block
// What this block does
// [RULE1] Status command returns byte; bit5 high-voltage not ready
// [RULE2] Status bit4 flags supply input below threshold
// [RULE3] Status bit2 reports busy, reset zero
// [RULE4] Status bits 1:0 carry fixed chip code
// [RULE5] Host trusts bits 5,4 only after 0x14/0x15
// [RULE6] Option command takes ten bytes; bit7 spare set
// [RULE7] Bytes two to six hold per-setting mode bits
// [RULE8] Sixth option byte bit6 enables buffer alternation
// [RULE9] No alternation for settings using mode one
// [RULE10] Option bytes seven to ten hold module id
// [RULE11] All ten option bytes exported for OTP storage
// [RULE12] User id command stores ten bytes
// [RULE13] Border byte bits 7:6 pick source; reset C0
// [RULE14] Fixed mode: bits 5:4 pick border level
// [RULE15] Grey mode: bit2 picks plain or red-common output
// [RULE16] Grey mode: bits 1:0 pick lookup table
// [RULE17] Read-select command picks plane for RAM reads
// [RULE18] Select line low means command, high parameter
// [RULE19] Parameters land in order; new command restarts
`ifndef EPDSC_REGS_SVH
`define EPDSC_REGS_SVH

`define EPDSC_CMD_STATUS 8'h2F
`define EPDSC_CMD_OPTION 8'h37
`define EPDSC_CMD_USERID 8'h38
`define EPDSC_CMD_BORDER 8'h3C
`define EPDSC_CMD_RDSEL 8'h41
`define EPDSC_BORDER_POR 8'hC0
`define EPDSC_NBYTES 4'hA
`define EPDSC_OPT_A_MASK 8'h80
`define EPDSC_OPT_F_MASK 8'h4F
`define EPDSC_BORDER_MASK 8'hF7
`define EPDSC_OPT_F_IDX 4'h5
`define EPDSC_PP_BIT 6
`define EPDSC_NSET 6'h24
`define EPDSC_RDSEL_BIT 0
// Arbitrary chip code, not tied to any real part
`define EPDSC_CHIP_ID 2'h2
`define EPDSC_SYNC_W 6

`endif

// file: hdl/epdsc_pkg.sv
// Types shared by the status/option/border command block
package epdsc_pkg;

    typedef enum logic [2:0] {
        CTX_IDLE = 3'b000,
        CTX_STATUS = 3'b001,
        CTX_OPTION = 3'b010,
        CTX_USERID = 3'b011,
        CTX_BORDER = 3'b100,
        CTX_RDSEL = 3'b101
    } epdsc_ctx_t;

    typedef enum logic [1:0] {
        BSRC_GREY = 2'b00,
        BSRC_FIXED = 2'b01,
        BSRC_COMMON = 2'b10,
        BSRC_HIZ = 2'b11
    } epdsc_bsrc_t;

    typedef struct packed {
        logic [1:0] zero_hi;
        logic hv_not_ready;
        logic supply_low;
        logic zero_3;
        logic busy;
        logic [1:0] chip_id;
    } epdsc_status_t;

    typedef struct packed {
        epdsc_bsrc_t source;
        logic [1:0] level;
        logic rsv;
        logic red_common;
        logic [1:0] lut;
    } epdsc_border_t;

    typedef struct packed {
        logic hiz;
        logic common;
        logic fixed;
        logic grey;
        logic [1:0] level;
        logic red_common;
        logic [1:0] lut;
    } epdsc_bdrive_t;

endpackage : epdsc_pkg

// file: hdl/epdsc_sync.sv
// Two-flop synchroniser for the pins coming from outside mclk
`timescale 1ns/1ps
`include "epdsc_regs.svh"
module epdsc_sync (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Levels
    input wire logic [`EPDSC_SYNC_W-1:0] din,
    output logic [`EPDSC_SYNC_W-1:0] dout
);
    logic [`EPDSC_SYNC_W-1:0] meta;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule : epdsc_sync

// file: hdl/epdsc_spi_shift.sv
// Byte shifter for the serial link, sampled on mclk
`timescale 1ns/1ps
module epdsc_spi_shift (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Synchronised link pins
    input wire logic sclk_s,
    input wire logic cs_n_s,
    input wire logic sdi_s,
    input wire logic dc_s,
    // Transmit side
    input wire logic tx_load,
    input wire logic [7:0] tx_byte,
    output logic sdo,
    // Receive side
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic rx_dc
);
    logic sclk_d;
    logic [2:0] cnt;
    logic [6:0] sh;
    logic [7:0] txsh;
    logic rise;
    logic fall;

    assign rise = sclk_s & ~sclk_d & ~cs_n_s;
    assign fall = ~sclk_s & sclk_d & ~cs_n_s;
    assign sdo = txsh[7];

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            sclk_d <= 1'b0;
        end else begin
            sclk_d <= sclk_s;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cnt <= 3'h0;
            sh <= 7'h00;
        end else if (cs_n_s) begin
            cnt <= 3'h0;
        end else if (rise) begin
            cnt <= cnt + 3'h1;
            sh <= {sh[5:0], sdi_s};
        end
    end

    // Select line taken with the last bit of each byte
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rx_valid <= 1'b0;
            rx_byte <= 8'h00;
            rx_dc <= 1'b0;
        end else begin
            rx_valid <= rise && (cnt == 3'h7);
            if (rise && (cnt == 3'h7)) begin
                rx_byte <= {sh, sdi_s};
                rx_dc <= dc_s;
            end
        end
    end

    // The fall right after a byte boundary keeps the fresh MSB on the pin
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            txsh <= 8'h00;
        end else if (tx_load) begin
            txsh <= tx_byte;
        end else if (fall && (cnt != 3'h0)) begin
            txsh <= {txsh[6:0], 1'b0};
        end
    end
endmodule : epdsc_spi_shift

// file: test/epdsc_host.sv
// Host model driving the serial command link of the status/option block
`timescale 1ns/1ps
module epdsc_host (
    // Link pins driven by the host
    output logic sclk,
    output logic cs_n,
    output logic dc,
    output logic sda,
    // Data wire as resolved between host and device
    input wire logic sda_wire
);
    // ****************************************
    // Frame and byte tasks, 125 ns link clock
    // ****************************************
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        dc = 1'b0;
        sda = 1'b0;
    end

    // One byte, MSB first; when reading the host keeps driving but toggles its
    // own level each bit, so an undriven wire shows a changing pattern
    task automatic xfer(input logic dcv, input logic rd,
                        input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            dc <= dcv;
            sda <= rd ? ~sda : tx[i];
            #62.5 sclk <= 1'b1;
            rx[i] = sda_wire;
            #62.5 sclk <= 1'b0;
        end
    endtask : xfer

    task automatic start();
        cs_n <= 1'b0;
        #62.5;
    endtask : start

    // Clock stays low between frames
    task automatic stop();
        #62.5 cs_n <= 1'b1;
        sda <= ~sda;
        #125;
    endtask : stop
endmodule : epdsc_host

// file: test/epdsc_core_bench.sv
// Self-checking bench for the status/option/border command block
`timescale 1ns/1ps
module epdsc_core_bench;
    import epdsc_pkg::*;
    // ****************************************
    // Environment
    // ****************************************
    // Chip code value is arbitrary
    localparam logic [1:0] ID_CODE = 2'h3;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic hv_not_ready = 1'b0;
    logic chip_supply_low = 1'b0;
    logic busy = 1'b0;
    logic [5:0] waveform_setting = 6'h00;
    logic link_sclk, link_cs_n, link_dc, host_sda, link_sda;
    logic link_sda_out, link_sda_oe_n, spare_common_electrode_voltage_sel, read_ram_red;
    logic alternating_ram_buffer_active;
    logic [79:0] display_option, user_identifier, uid_exp;
    logic [35:0] display_mode2;
    logic [31:0] module_id;
    epdsc_border_t border_waveform_select;
    epdsc_bdrive_t border_drive_output;
    epdsc_bdrive_t bd;
    logic [7:0] rx, b;
    logic [7:0] pq[$];
    logic [5:0] ws_tab[4] = '{6'h00, 6'h01, 6'h23, 6'h24};
    logic [35:0] m2;
    int n_mismatch = 0;
    int cmp_count = 0;

    always #2 mclk = ~mclk;
    assign link_sda = !link_sda_oe_n ? link_sda_out : host_sda;

    epdsc_core #(.CHIP_ID(ID_CODE)) dut (
        .mclk(mclk), .reset(reset), .link_sclk(link_sclk),
        .link_cs_n(link_cs_n), .link_dc(link_dc), .link_sda_in(link_sda),
        .link_sda_out(link_sda_out), .link_sda_oe_n(link_sda_oe_n),
        .hv_not_ready(hv_not_ready), .chip_supply_low(chip_supply_low),
        .busy(busy), .waveform_setting(waveform_setting),
        .display_option(display_option), .user_identifier(user_identifier),
        .spare_common_electrode_voltage_sel(spare_common_electrode_voltage_sel), .display_mode2(display_mode2),
        .module_id(module_id),
        .alternating_ram_buffer_active(alternating_ram_buffer_active),
        .border_waveform_select(border_waveform_select),
        .border_drive_output(border_drive_output),
        .read_ram_red(read_ram_red));

    epdsc_host host (.sclk(link_sclk), .cs_n(link_cs_n), .dc(link_dc),
        .sda(host_sda), .sda_wire(link_sda));

    task automatic chk(input string nm, input logic [79:0] exp,
                       input logic [79:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic send(input logic [7:0] c);
        host.start();
        host.xfer(1'b0, 1'b0, c, rx);
        foreach (pq[i]) host.xfer(1'b1, 1'b0, pq[i], rx);
        host.stop();
    endtask : send

    task automatic status(input logic [2:0] s);
        logic [7:0] exp;
        exp = {2'b00, s[2], s[1], 1'b0, s[0], ID_CODE};
        @(posedge mclk);
        {hv_not_ready, chip_supply_low, busy} <= s;
        repeat (8) @(posedge mclk);
        host.start();
        host.xfer(1'b0, 1'b0, 8'h14, rx);
        host.xfer(1'b0, 1'b0, 8'h15, rx);
        host.xfer(1'b0, 1'b0, 8'h2F, rx);
        host.xfer(1'b1, 1'b1, 8'h00, rx);
        chk("status", exp, rx);
        host.stop();
        chk("sda_oe_n", 80'h1, link_sda_oe_n);
    endtask : status

    function automatic epdsc_bdrive_t bdrive(input logic [7:0] v);
        epdsc_bdrive_t d;
        d = '0;
        d.hiz = (v[7:6] == 2'h3);
        d.common = (v[7:6] == 2'h2);
        d.fixed = (v[7:6] == 2'h1);
        d.grey = (v[7:6] == 2'h0);
        if (d.fixed) d.level = v[5:4];
        if (d.grey) {d.red_common, d.lut} = v[2:0];
        return d;
    endfunction : bdrive

    task automatic close_out();
        $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        #200000;
        n_mismatch++;
        $display("Error watchdog expected finish seen timeout");
        close_out();
    end

    initial begin
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
        repeat (4) @(posedge mclk);
        chk("border", 80'hC0, border_waveform_select);
        chk("drive", 80'h100, border_drive_output);
        chk("option", 80'h0, display_option);
        chk("alt", 80'h0, alternating_ram_buffer_active);
        $display("Test reset done");
        for (int i = 0; i < 4; i++) status(3'(3'h4 >> i));
        $display("Test status done");
        // Bits outside the documented fields must be dropped
        pq = '{8'hFF, 8'hA5, 8'h3C, 8'h81, 8'h7E, 8'hFF,
               8'h11, 8'h22, 8'h33, 8'h44};
        send(8'h37);
        m2 = 36'hF_7E81_3CA5;
        chk("opt", 80'h4433_2211_4F7E_813C_A580, display_option);
        chk("spare", 80'h1, spare_common_electrode_voltage_sel);
        chk("mode2", m2, display_mode2);
        chk("module_id", 80'h4433_2211, module_id);
        foreach (ws_tab[i]) begin
            waveform_setting <= ws_tab[i];
            repeat (4) @(posedge mclk);
            b = (ws_tab[i] < 6'h24) ? m2[ws_tab[i]] : 1'b0;
            chk("alt", b, alternating_ram_buffer_active);
        end
        // Short rewrite: enable cleared, later bytes keep old values
        pq = '{8'h80, 8'h01, 8'h00, 8'h00, 8'h00, 8'h0F};
        send(8'h37);
        waveform_setting <= 6'h00;
        repeat (4) @(posedge mclk);
        chk("opt", 80'h4433_2211_0F00_0000_0180, display_option);
        chk("alt", 80'h0, alternating_ram_buffer_active);
        $display("Test option done");
        pq.delete();
        for (int i = 0; i < 11; i++) pq.push_back(8'(8'hA0 + i));
        for (int i = 0; i < 10; i++) uid_exp[i*8 +: 8] = 8'(8'hA0 + i);
        send(8'h38);
        chk("user_id", uid_exp, user_identifier);
        $display("Test user id done");
        foreach (pq[i]) pq[i] = 8'h00;
        pq = '{8'h0F, 8'h02, 8'h05, 8'h00, 8'h40, 8'h5C, 8'h6B, 8'h70,
               8'hBF, 8'hC0};
        for (int i = 0; i < 10; i++) begin
            b = pq[i];
            host.start();
            host.xfer(1'b0, 1'b0, 8'h3C, rx);
            host.xfer(1'b1, 1'b0, b, rx);
            host.xfer(1'b1, 1'b0, 8'h00, rx);
            host.stop();
            chk("border", b & 8'hF7, border_waveform_select);
            bd = bdrive(b);
            chk("drv", bd, border_drive_output);
        end
        $display("Test border done");
        pq = '{8'h01};
        send(8'h41);
        chk("ram_red", 80'h1, read_ram_red);
        // A byte with select low is a command even mid-parameters
        host.start();
        host.xfer(1'b0, 1'b0, 8'h3C, rx);
        host.xfer(1'b0, 1'b0, 8'h41, rx);
        host.xfer(1'b1, 1'b0, 8'h00, rx);
        host.stop();
        chk("ram_red", 80'h0, read_ram_red);
        chk("border", 80'hC0, border_waveform_select);
        $display("Test read select done");
        close_out();
    end
endmodule : epdsc_core_bench
